// ===== epis_sequencer.v
// What this block does
// - Fibrillation train spacing 50 or 30 ms.
// - Fibrillation runs only while hold and link.
// - Detection suspended during fibrillation, then re-enabled.
// - Open episode closed before first induction pulse.
// - Markers and electrograms halted during fibrillation.
// - Up to 30 drives then four extra stimuli.
// - First drive one interval after last beat.
// - Sequence pulses asynchronous, chosen chamber, pacing outputs.
// - Cycle lengths 120 to 750 ms, 10 ms steps, off.
// - Extra stimuli stop at first one set off.
// - Link loss ignored; abort, magnet or disarm ends sequence.
// - Repeated start reloads remaining drive count.
// - Sequence completes after last stimulus, detection restarts.
// - Sequence command ends episode; not logged as therapy.
// - Shock drive train paced, lookback 3000 ms.
// - Shock drive interval 120 to 750, count 1 to 30.
// - Shock timed from last drive, 1 to 500 ms.
// - Shock induction completes then detection restarts.
// - Induction shocks leave episode and therapy counters unchanged.
// - Inhibit blinds detection only while link present.
// - Inhibit request ignored while episode open.
// - Detect command clears inhibit, resumes detection.
// - Only one test function armed at a time.
// - Magnet present suppresses all induction delivery.
`timescale 1ns/1ns
`include "epis_map.vh"
module epis_sequencer #(
  parameter MS_CYC = `EPIS_CYC_PER_MS
) (
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire       link_ok_in,
  input  wire       magnet_in,
  input  wire       episode_open_in,
  input  wire       beat_in,
  input  wire       arm_fib_in,
  input  wire       arm_seq_in,
  input  wire       arm_sot_in,
  input  wire       arm_ext_in,
  input  wire       fib_hold_in,
  input  wire       fib_high_in,
  input  wire       start_in,
  input  wire       abort_therapy_command_in,
  input  wire       inhibit_cmd_in,
  input  wire       detect_cmd_in,
  input  wire       chamber_atrial_in,
  input  wire [4:0] drive_count_in,
  input  wire [6:0] drive_cl_in,
  input  wire [6:0] extra_cl0_in,
  input  wire [6:0] extra_cl1_in,
  input  wire [6:0] extra_cl2_in,
  input  wire [6:0] extra_cl3_in,
  input  wire [8:0] couple_ms_in,
  output reg        fib_pulse_out,
  output reg        atrial_pace_out,
  output reg        vent_pace_out,
  output reg        shock_out,
  output reg        detect_enable_out,
  output reg        close_episode_out,
  output reg        telemetry_stream_out,
  output reg        seq_busy_out,
  output reg        log_therapy_out
);
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_FIB   = 7'h02;
  localparam [6:0] S_CLOSE = 7'h04;
  localparam [6:0] S_DRIVE = 7'h08;
  localparam [6:0] S_EXTRA = 7'h10;
  localparam [6:0] S_COUP  = 7'h20;
  localparam [6:0] S_EXT   = 7'h40;
  localparam [2:0] A_NONE = 3'h0;
  localparam [2:0] A_FIB  = 3'h1;
  localparam [2:0] A_SEQ  = 3'h2;
  localparam [2:0] A_SOT  = 3'h3;
  localparam [2:0] A_EXT  = 3'h4;

  // Cycle-length code to ms; codes run 120..750 in 10 ms steps, zero is off.
  function [11:0] cl_ms;
    input [6:0] code;
    begin
      if (code == `EPIS_CL_OFF)
        cl_ms = 12'h000;
      else if (code > `EPIS_CL_MAX_CODE)
        cl_ms = `EPIS_CL_MAX_MS;
      else
        cl_ms = `EPIS_CL_MIN_MS - `EPIS_CL_STEP_MS + {5'h00, code} * `EPIS_CL_STEP_MS;
    end
  endfunction

  // A count of zero would leave no drive pulse to time the extras from, so it runs one.
  function [4:0] drive_load;
    input [4:0] count;
    begin
      if (count == 5'h00)
        drive_load = 5'h01;
      else if (count > `EPIS_MAX_DRIVE)
        drive_load = `EPIS_MAX_DRIVE;
      else
        drive_load = count;
    end
  endfunction

  reg [1:0]  link_s_ff, mag_s_ff, epi_s_ff, beat_s_ff;
  reg [1:0]  hold_s_ff, high_s_ff, start_s_ff, abort_s_ff, inh_s_ff, det_s_ff;
  reg        beat_d_ff, start_d_ff, inh_d_ff, det_d_ff;
  reg [6:0]  state_ff;
  reg [2:0]  armed_ff;
  reg [2:0]  arm_prev_ff;
  reg        inhibit_ff;
  reg        sot_ff;
  reg [4:0]  left_ff;
  reg [1:0]  xi_ff;
  reg [23:0] presc_ff;
  reg [11:0] ms_ff;
  reg [11:0] since_ff;
  reg [11:0] target_ff;
  reg [3:0]  pw_ff;
  reg        tick_ff;
  // Settings arrive from the telemetry side and are resynchronised like any pin.
  // Bits settle on their own, so a word changed at a start edge may be seen torn.
  wire [53:0] cfg_raw = {arm_fib_in, arm_seq_in, arm_sot_in, arm_ext_in, chamber_atrial_in,
                         drive_count_in, drive_cl_in, extra_cl0_in, extra_cl1_in,
                         extra_cl2_in, extra_cl3_in, couple_ms_in};
  wire [53:0] cfg_s;
  genvar      gi;
  generate
    for (gi = 0; gi < 54; gi = gi + 1) begin : g_cfg_sync
      reg [1:0] sync_ff;
      always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
          sync_ff <= 2'h0;
        else
          sync_ff <= {sync_ff[0], cfg_raw[gi]};
      end
      assign cfg_s[gi] = sync_ff[1];
    end
  endgenerate
  wire [3:0] arm_s     = cfg_s[53:50];
  wire       chamber_a = cfg_s[49];
  wire [4:0] drive_cnt = cfg_s[48:44];
  wire [6:0] drive_cl  = cfg_s[43:37];
  wire [6:0] extra_cl0 = cfg_s[36:30];
  wire [6:0] extra_cl1 = cfg_s[29:23];
  wire [6:0] extra_cl2 = cfg_s[22:16];
  wire [6:0] extra_cl3 = cfg_s[15:9];
  wire [8:0] couple_ms = cfg_s[8:0];
  wire       link  = link_s_ff[1];
  wire       mag   = mag_s_ff[1];
  wire       epi   = epi_s_ff[1];
  wire       hold  = hold_s_ff[1];
  wire       abort = abort_s_ff[1];
  wire       beat_p  = beat_s_ff[1] & ~beat_d_ff;
  wire       start_p = start_s_ff[1] & ~start_d_ff;
  wire       inh_p   = inh_s_ff[1] & ~inh_d_ff;
  wire       det_p   = det_s_ff[1] & ~det_d_ff;
  wire       due     = tick_ff & (ms_ff + 12'h001 >= target_ff);
  wire [6:0] extra_sel = (xi_ff == 2'h0) ? extra_cl0 :
                         (xi_ff == 2'h1) ? extra_cl1 :
                         (xi_ff == 2'h2) ? extra_cl2 : extra_cl3;
  wire [2:0] arm_req = arm_s[3] ? A_FIB : arm_s[2] ? A_SEQ :
                       arm_s[1] ? A_SOT : arm_s[0] ? A_EXT : A_NONE;
  wire [11:0] first_wait = (since_ff >= cl_ms(drive_cl)) ? 12'h001 :
                           cl_ms(drive_cl) - since_ff;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_s_ff  <= 2'h0;
      mag_s_ff   <= 2'h0;
      epi_s_ff   <= 2'h0;
      beat_s_ff  <= 2'h0;
      hold_s_ff  <= 2'h0;
      high_s_ff  <= 2'h0;
      start_s_ff <= 2'h0;
      abort_s_ff <= 2'h0;
      inh_s_ff   <= 2'h0;
      det_s_ff   <= 2'h0;
      beat_d_ff  <= 1'b0;
      start_d_ff <= 1'b0;
      inh_d_ff   <= 1'b0;
      det_d_ff   <= 1'b0;
    end else begin
      link_s_ff  <= {link_s_ff[0], link_ok_in};
      mag_s_ff   <= {mag_s_ff[0], magnet_in};
      epi_s_ff   <= {epi_s_ff[0], episode_open_in};
      beat_s_ff  <= {beat_s_ff[0], beat_in};
      hold_s_ff  <= {hold_s_ff[0], fib_hold_in};
      high_s_ff  <= {high_s_ff[0], fib_high_in};
      start_s_ff <= {start_s_ff[0], start_in};
      abort_s_ff <= {abort_s_ff[0], abort_therapy_command_in};
      inh_s_ff   <= {inh_s_ff[0], inhibit_cmd_in};
      det_s_ff   <= {det_s_ff[0], detect_cmd_in};
      beat_d_ff  <= beat_s_ff[1];
      start_d_ff <= start_s_ff[1];
      inh_d_ff   <= inh_s_ff[1];
      det_d_ff   <= det_s_ff[1];
    end
  end

  // One shared millisecond base; every interval except the pulse width, which counts clock cycles, is counted against it.
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      presc_ff <= 24'h000000;
      tick_ff  <= 1'b0;
      since_ff <= 12'h000;
    end else begin
      tick_ff  <= (presc_ff == MS_CYC - 1);
      presc_ff <= (presc_ff == MS_CYC - 1) ? 24'h000000 : presc_ff + 24'h000001;
      if (beat_p || vent_pace_out || atrial_pace_out)
        since_ff <= 12'h000;
      else if (tick_ff && since_ff < `EPIS_LOOKBACK_MS)
        since_ff <= since_ff + 12'h001;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff    <= S_IDLE;
      armed_ff    <= A_NONE;
      arm_prev_ff <= A_NONE;
      inhibit_ff  <= 1'b0;
      sot_ff      <= 1'b0;
      left_ff     <= 5'h00;
      xi_ff       <= 2'h0;
      ms_ff       <= 12'h000;
      target_ff   <= 12'h001;
      pw_ff       <= 4'h0;
      fib_pulse_out        <= 1'b0;
      atrial_pace_out      <= 1'b0;
      vent_pace_out        <= 1'b0;
      shock_out            <= 1'b0;
      detect_enable_out    <= 1'b1;
      close_episode_out    <= 1'b0;
      telemetry_stream_out <= 1'b1;
      seq_busy_out         <= 1'b0;
      log_therapy_out      <= 1'b0;
    end else begin
      close_episode_out <= 1'b0;
      log_therapy_out   <= 1'b0;
      shock_out         <= 1'b0;
      arm_prev_ff       <= arm_req;
      if (arm_req != A_NONE && arm_req != arm_prev_ff)
        armed_ff <= arm_req;
      if (tick_ff)
        ms_ff <= ms_ff + 12'h001;
      if (pw_ff != 4'h0)
        pw_ff <= pw_ff - 4'h1;
      else begin
        fib_pulse_out   <= 1'b0;
        atrial_pace_out <= 1'b0;
        vent_pace_out   <= 1'b0;
      end
      case (state_ff)
        S_IDLE: begin
          detect_enable_out    <= 1'b1;
          telemetry_stream_out <= 1'b1;
          seq_busy_out         <= 1'b0;
          if (!mag) begin
            if (armed_ff == A_FIB && hold && link) begin
              state_ff          <= S_FIB;
              close_episode_out <= epi;
              detect_enable_out <= 1'b0;
              telemetry_stream_out <= 1'b0;
              ms_ff     <= 12'h000;
              target_ff <= 12'h001;
            end else if ((armed_ff == A_SEQ || armed_ff == A_SOT) && start_p) begin
              state_ff          <= S_CLOSE;
              sot_ff            <= (armed_ff == A_SOT);
              close_episode_out <= epi;
              detect_enable_out <= 1'b0;
              seq_busy_out      <= 1'b1;
            end else if (armed_ff == A_EXT && inh_p && !epi) begin
              inhibit_ff <= 1'b1;
              state_ff   <= S_EXT;
            end
          end
        end
        S_FIB: begin
          if (!hold || !link || mag || armed_ff != A_FIB) begin
            state_ff <= S_IDLE;
          end else if (due) begin
            fib_pulse_out <= 1'b1;
            pw_ff         <= `EPIS_PULSE_CYC;
            ms_ff         <= 12'h000;
            target_ff     <= high_s_ff[1] ? `EPIS_FIB_HIGH_MS : `EPIS_FIB_LOW_MS;
          end
        end
        S_CLOSE: begin
          // Episode closure was issued last cycle, so pacing can now be timed.
          state_ff  <= S_DRIVE;
          left_ff   <= drive_load(drive_cnt);
          xi_ff     <= 2'h0;
          ms_ff     <= 12'h000;
          target_ff <= first_wait;
        end
        S_DRIVE, S_EXTRA, S_COUP: begin
          if (abort || mag) begin
            state_ff <= S_IDLE;
          end else if (state_ff == S_DRIVE && start_p && !sot_ff) begin
            left_ff <= drive_load(drive_cnt);
          end else if (due) begin
            ms_ff <= 12'h000;
            if (state_ff == S_COUP) begin
              shock_out <= 1'b1;
              state_ff  <= S_IDLE;
            end else begin
              pw_ff <= `EPIS_PULSE_CYC;
              if (sot_ff)
                vent_pace_out <= 1'b1;
              else if (chamber_a)
                atrial_pace_out <= 1'b1;
              else
                vent_pace_out <= 1'b1;
              if (state_ff == S_DRIVE && left_ff > 5'h01) begin
                left_ff   <= left_ff - 5'h01;
                target_ff <= cl_ms(drive_cl);
              end else if (sot_ff) begin
                state_ff  <= S_COUP;
                target_ff <= ({3'h0, couple_ms} > `EPIS_COUPLE_MAX_MS) ? `EPIS_COUPLE_MAX_MS :
                             (couple_ms == 9'h000) ? 12'h001 : {3'h0, couple_ms};
              end else if (state_ff == S_DRIVE) begin
                state_ff <= (extra_cl0 == `EPIS_CL_OFF) ? S_IDLE : S_EXTRA;
                target_ff <= cl_ms(extra_cl0);
              end else if (xi_ff == 2'h3 || extra_sel == `EPIS_CL_OFF) begin
                state_ff <= S_IDLE;
              end else begin
                xi_ff     <= xi_ff + 2'h1;
                target_ff <= (xi_ff == 2'h0) ? cl_ms(extra_cl1) :
                             (xi_ff == 2'h1) ? cl_ms(extra_cl2) : cl_ms(extra_cl3);
                if (((xi_ff == 2'h0) ? extra_cl1 : (xi_ff == 2'h1) ? extra_cl2
                     : extra_cl3) == `EPIS_CL_OFF)
                  state_ff <= S_IDLE;
              end
            end
          end
        end
        S_EXT: begin
          // Blinding follows the link so an unseen device is never left blind.
          detect_enable_out    <= !(inhibit_ff && link);
          telemetry_stream_out <= 1'b0;
          if (det_p || armed_ff != A_EXT) begin
            inhibit_ff <= 1'b0;
            state_ff   <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
      if (armed_ff != A_SEQ && armed_ff != A_SOT && (state_ff == S_DRIVE ||
          state_ff == S_EXTRA || state_ff == S_COUP))
        state_ff <= S_IDLE;
    end
  end
endmodule

// ===== epis_map.vh
`ifndef EPIS_MAP_VH
`define EPIS_MAP_VH
`define EPIS_CLK_HZ          10000000
`define EPIS_CYC_PER_MS      (`EPIS_CLK_HZ / 1000)
`define EPIS_FIB_LOW_MS      12'h032
`define EPIS_FIB_HIGH_MS     12'h01E
`define EPIS_MAX_DRIVE       5'h1E
`define EPIS_CL_MIN_MS       12'h078
`define EPIS_CL_MAX_MS       12'h2EE
`define EPIS_CL_STEP_MS      12'h00A
`define EPIS_CL_MAX_CODE     7'h40
`define EPIS_LOOKBACK_MS     12'hBB8
`define EPIS_COUPLE_MAX_MS   12'h1F4
`define EPIS_CL_OFF          7'h00
`define EPIS_PULSE_CYC       4'h5
`endif

// ===== epis_seq_sva.sv
`timescale 1ns/1ns
module epis_seq_sva (
  input wire clk_in,
  input wire resetn_in,
  input wire link_ok_in,
  input wire magnet_in,
  input wire abort_therapy_command_in,
  input wire fib_pulse_out,
  input wire atrial_pace_out,
  input wire vent_pace_out,
  input wire shock_out,
  input wire detect_enable_out,
  input wire close_episode_out,
  input wire telemetry_stream_out,
  input wire seq_busy_out,
  input wire log_therapy_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // Spans allow for the two-flop input synchronisers plus the output register.
  a_fib_blinds: assert property ($rose(fib_pulse_out) |-> !detect_enable_out)
    else $error("detect on at fib");
  a_fib_mute: assert property ($rose(fib_pulse_out) |-> !telemetry_stream_out)
    else $error("stream on at fib");
  a_fib_link: assert property ((!link_ok_in) [*4] |-> !$rose(fib_pulse_out))
    else $error("fib without link");
  a_magnet_quiet: assert property (magnet_in [*8] |=> ##1
    !(fib_pulse_out || shock_out || vent_pace_out || atrial_pace_out)) else $error("magnet");
  a_vent_width: assert property ($rose(vent_pace_out) |-> vent_pace_out [*6] ##1 !vent_pace_out)
    else $error("vent width");
  a_atr_width: assert property ($rose(atrial_pace_out) |-> atrial_pace_out [*6] ##1 !atrial_pace_out)
    else $error("atrial width");
  a_shock_single: assert property (shock_out |=> !shock_out) else $error("shock width");
  a_no_log: assert property (!log_therapy_out) else $error("therapy logged");
  a_close_clean: assert property (close_episode_out |-> !(fib_pulse_out || vent_pace_out ||
    atrial_pace_out)) else $error("close with pulse");
  a_busy_blinds: assert property (seq_busy_out |-> !detect_enable_out) else $error("busy det");
  a_abort_stop: assert property (abort_therapy_command_in [*5] |=> !seq_busy_out)
    else $error("abort ignored");
  cover property ($rose(fib_pulse_out));
  cover property (close_episode_out);
  cover property (shock_out);
  cover property ($fell(seq_busy_out));
endmodule

// ===== epis_programmer.sv
`timescale 1ns/1ns
module epis_programmer (
  input  wire clk_in,
  input  wire want_link_in,
  input  wire want_hold_in,
  output reg  link_ok_out,
  output reg  fib_hold_out
);
  initial begin
    link_ok_out = 1'h0;
    fib_hold_out = 1'h0;
  end
  // Commands move only between clock edges, as a real link would deliver them.
  always @(negedge clk_in) begin
    link_ok_out <= want_link_in;
    fib_hold_out <= want_hold_in;
  end
endmodule

// ===== epis_sequencer_test.sv
`timescale 1ns/1ns
module epis_sequencer_test;
  reg        clk_in, resetn_in, magnet_in, episode_open_in, beat_in, want_link, want_hold;
  reg        arm_fib_in, arm_seq_in, arm_sot_in, arm_ext_in, fib_high_in, start_in, abort_in;
  reg        inhibit_cmd_in, detect_cmd_in, chamber_atrial_in, fq, vq, aq;
  reg  [4:0] drive_count_in;
  reg  [6:0] drive_cl_in, ex0, ex1, ex2, ex3;
  reg  [8:0] couple_ms_in;
  wire       link_ok_in, fib_hold_in, fib_pulse_out, atrial_pace_out, vent_pace_out, shock_out;
  wire       detect_enable_out, close_episode_out, telemetry_stream_out, seq_busy_out;
  wire       log_therapy_out;
  integer    n_errors, n_checks, cyc, n_fib, n_v, n_a, n_shk, n_cls, t_prev, t_last;
  integer    t_beat, t_shk;
  epis_programmer i_epis_programmer (.clk_in(clk_in), .want_link_in(want_link),
    .want_hold_in(want_hold), .link_ok_out(link_ok_in), .fib_hold_out(fib_hold_in));
  epis_sequencer #(.MS_CYC(10)) i_epis_sequencer (.clk_in(clk_in), .resetn_in(resetn_in),
    .link_ok_in(link_ok_in), .magnet_in(magnet_in), .episode_open_in(episode_open_in),
    .beat_in(beat_in), .arm_fib_in(arm_fib_in), .arm_seq_in(arm_seq_in),
    .arm_sot_in(arm_sot_in), .arm_ext_in(arm_ext_in), .fib_hold_in(fib_hold_in),
    .fib_high_in(fib_high_in), .start_in(start_in), .abort_therapy_command_in(abort_in),
    .inhibit_cmd_in(inhibit_cmd_in), .detect_cmd_in(detect_cmd_in),
    .chamber_atrial_in(chamber_atrial_in), .drive_count_in(drive_count_in),
    .drive_cl_in(drive_cl_in), .extra_cl0_in(ex0), .extra_cl1_in(ex1), .extra_cl2_in(ex2),
    .extra_cl3_in(ex3), .couple_ms_in(couple_ms_in), .fib_pulse_out(fib_pulse_out),
    .atrial_pace_out(atrial_pace_out), .vent_pace_out(vent_pace_out), .shock_out(shock_out),
    .detect_enable_out(detect_enable_out), .close_episode_out(close_episode_out),
    .telemetry_stream_out(telemetry_stream_out), .seq_busy_out(seq_busy_out),
    .log_therapy_out(log_therapy_out));
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  // Outputs are sampled at the falling edge, where they have settled.
  always @(negedge clk_in) begin
    cyc = cyc + 1;
    if ((fib_pulse_out && !fq) || (vent_pace_out && !vq) || (atrial_pace_out && !aq)) begin
      t_prev = t_last;
      t_last = cyc;
    end
    n_fib = n_fib + (fib_pulse_out === 1'h1 && !fq);
    n_v = n_v + (vent_pace_out === 1'h1 && !vq);
    n_a = n_a + (atrial_pace_out === 1'h1 && !aq);
    n_shk = n_shk + (shock_out === 1'h1);
    n_cls = n_cls + (close_episode_out === 1'h1);
    if (shock_out === 1'h1)
      t_shk = cyc;
    fq = fib_pulse_out === 1'h1;
    vq = vent_pace_out === 1'h1;
    aq = atrial_pace_out === 1'h1;
  end
  task tick(input integer n);
    repeat (n) @(negedge clk_in);
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task clr;
    {n_fib, n_v, n_a, n_shk, n_cls, t_prev, t_last, t_shk} = 0;
  endtask
  task go;
    tick(5);
    start_in = 1'h1;
    tick(5);
    start_in = 1'h0;
  endtask
  task idle;
    integer k;
    k = 0;
    tick(20);
    while (seq_busy_out !== 1'h0 && k < 9000) begin
      tick(1);
      k = k + 1;
    end
    chk("busy", 0, seq_busy_out);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    tick(60000);
    n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    {magnet_in, episode_open_in, beat_in, want_link, want_hold, arm_fib_in, arm_seq_in} = 0;
    {arm_sot_in, arm_ext_in, fib_high_in, start_in, abort_in, inhibit_cmd_in, fq, vq, aq} = 0;
    {detect_cmd_in, chamber_atrial_in, drive_count_in, drive_cl_in, ex0, ex1, ex2, ex3} = 0;
    {couple_ms_in, n_errors, n_checks, cyc, resetn_in} = 0;
    clr;
    tick(3);
    resetn_in = 1'h1;
    tick(4);
    chk("reset detect", 1, detect_enable_out);
    chk("reset stream", 1, telemetry_stream_out);
    {arm_fib_in, want_link, fib_high_in, episode_open_in, want_hold} = 5'h1F;
    tick(800);
    chk("fib high gap", 300, t_last - t_prev);
    chk("fib close", 1, n_cls);
    chk("fib detect", 0, detect_enable_out);
    chk("fib stream", 0, telemetry_stream_out);
    {episode_open_in, want_link} = 2'h0;
    tick(20);
    clr;
    tick(700);
    chk("fib no link", 0, n_fib);
    chk("fib detect back", 1, detect_enable_out);
    chk("fib stream back", 1, telemetry_stream_out);
    {fib_high_in, want_link} = 2'h1;
    tick(1200);
    chk("fib low gap", 500, t_last - t_prev);
    want_hold = 1'h0;
    tick(20);
    clr;
    tick(700);
    chk("fib no hold", 0, n_fib);
    $display("test fib done");
    {arm_fib_in, arm_seq_in, episode_open_in} = 3'h3;
    {drive_count_in, drive_cl_in, ex0, ex1, ex2} = {5'h02, 7'h01, 7'h02, 7'h00, 7'h03};
    go;
    want_link = 1'h0;
    idle;
    chk("seq pulses", 3, n_v);
    chk("seq gap", 1300, t_last - t_prev);
    chk("seq chamber", 0, n_a);
    chk("seq close", 1, n_cls);
    chk("seq detect", 1, detect_enable_out);
    chk("no log", 0, log_therapy_out);
    {episode_open_in, chamber_atrial_in, drive_count_in, ex0} = {2'h1, 5'h03, 7'h00};
    clr;
    go;
    while (n_a == 0 && cyc < 40000)
      tick(1);
    go;
    idle;
    chk("reload pulses", 4, n_a);
    chk("atrial only", 0, n_v);
    $display("test sequence done");
    drive_count_in = 5'h1E;
    go;
    tick(2000);
    abort_in = 1'h1;
    tick(10);
    chk("abort busy", 0, seq_busy_out);
    clr;
    tick(1500);
    chk("abort quiet", 0, n_a);
    {abort_in, magnet_in} = 2'h1;
    go;
    tick(2000);
    chk("magnet quiet", 0, n_a);
    magnet_in = 1'h0;
    $display("test abort magnet done");
    {arm_seq_in, arm_sot_in, drive_count_in, couple_ms_in} = {2'h1, 5'h02, 9'h005};
    clr;
    beat_in = 1'h1;
    t_beat = cyc;
    go;
    tick(3000);
    chk("drive shock pulses", 2, n_v);
    chk("drive gap", 1200, t_last - t_prev);
    chk("lookback", 1, t_prev - t_beat > 1180 && t_prev - t_beat < 1240);
    chk("couple gap", 50, t_shk - t_last);
    chk("drive shock", 1, n_shk);
    chk("shock no log", 0, log_therapy_out);
    chk("shock detect", 1, detect_enable_out);
    clr;
    go;
    tick(500);
    {arm_sot_in, arm_ext_in, want_link} = 3'h3;
    tick(3000);
    chk("disarmed shock", 0, n_shk);
    $display("test drive shock done");
    inhibit_cmd_in = 1'h1;
    tick(10);
    chk("inhibit", 0, detect_enable_out);
    want_link = 1'h0;
    tick(10);
    chk("inhibit no link", 1, detect_enable_out);
    want_link = 1'h1;
    tick(10);
    chk("inhibit relink", 0, detect_enable_out);
    {inhibit_cmd_in, detect_cmd_in} = 2'h1;
    tick(10);
    chk("detect cmd", 1, detect_enable_out);
    {episode_open_in, inhibit_cmd_in} = 2'h3;
    tick(10);
    chk("inhibit refused", 1, detect_enable_out);
    $display("test external done");
    end_of_test;
  end
endmodule
bind epis_sequencer epis_seq_sva i_epis_seq_sva (.clk_in(clk_in), .resetn_in(resetn_in),
  .link_ok_in(link_ok_in), .magnet_in(magnet_in),
  .abort_therapy_command_in(abort_therapy_command_in), .fib_pulse_out(fib_pulse_out),
  .atrial_pace_out(atrial_pace_out), .vent_pace_out(vent_pace_out), .shock_out(shock_out),
  .detect_enable_out(detect_enable_out), .close_episode_out(close_episode_out),
  .telemetry_stream_out(telemetry_stream_out), .seq_busy_out(seq_busy_out),
  .log_therapy_out(log_therapy_out));
